//--- core/led_scan_regs.svh
/*
  constants of the lamp scan controller: register offsets, field positions,
  reset values and time-base counts.
  assumes a 200 MHz core clock and the display memory window at 1000h.
*/
// Overview of operation
// - pin-enable bit low switches all scan-driven pins off; high drives them.
// - dot mode size field low bits: 4x5, 5x6, 6x7, 7x8.
// - size upper bit set selects 4x5 starting at lamp pin three.
// - engine select low means display-glass engine, high means lamp engine.
// - scan-mode bit high cycles frames; low scans once then interrupts.
// - high-current lock drives common pins from gpio where common select is set; other scan setup ignored.
// - lamp mode bit high is dot matrix, low is row/column matrix.
// - first on-time is (period value plus one) times 16 us.
// - second on-time, dot mode only, is (value plus one) times 16 us.
// - each group lasts the longer of the two on-times.
// - status bit 0 set on interrupt; cleared by writing 0 or scan-on.
// - interrupt reaches the core only when enable bit 6 is set.
// - flag register bit 6 shows pending interrupt; writing 0 clears it.
// - priority bit 6 high gives the interrupt high priority.
// - 4-bit drive-strength code held on secondary bus, higher means more.
// - 3-bit start pad picks first dot pin; only with size bit 2 clear.
// - matrix segment slot (value+1)*16 us, common slot adds 8 us.
// - matrix segment duty 1/8 to 8/8 from 3-bit duty field.
// - in row/column matrix modes only common lines with select bit set are scanned; others are gpio.
// - segment-select bits set make pins segment lines; others gpio.
// - 4x4 mode: pins 0-3 commons, 4-7 segments, common polarity selectable.
// - matrix reads one byte per common at 1000h-1007h, bit n is segment n.
// - duty values 0 to 7 give 1/8 through 8/8 conduction.
// - clearing scan enable resets every internal scan state.
// - interrupt mode scans one frame and stops; cyclic restarts frames.
// - dot mode on-bits at 1000h-1006h, on-time select bits at 1007h-100dh.
`ifndef LED_SCAN_REGS_SVH
`define LED_SCAN_REGS_SVH

// ---------------------------------------------------------------
// special function register offsets
// ---------------------------------------------------------------
`define OFS_IRQ_STATUS      8'hae
`define OFS_SCAN_ON         8'haf
`define OFS_DISP_CONTROL    8'hb1
`define OFS_DISP_MODE       8'hb2
`define OFS_FIRST_PERIOD    8'hb3
`define OFS_SECOND_PERIOD   8'hb4
`define OFS_FOUR_BY_FOUR    8'hb9
`define OFS_IRQ_ENABLE_ONE  8'he6
`define OFS_IRQ_FLAG_ONE    8'hf1
`define OFS_IRQ_PRIO_ONE    8'hf6

// ---------------------------------------------------------------
// secondary bus offsets
// ---------------------------------------------------------------
`define OFS_COMMON_SELECT   8'h23
`define OFS_SEGMENT_SELECT  8'h24
`define OFS_DRIVE_STRENGTH  8'h31
`define OFS_START_PAD       8'h58

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BIT_PIN_ENABLE      6
`define BIT_DUTY_HI         5
`define BIT_DUTY_LO         3
`define BIT_ENGINE_SELECT   2
`define BIT_SCAN_CYCLIC     1
`define BIT_HIGH_CURRENT    0
`define BIT_LAMP_MODE       7
`define BIT_COMMON_INVERT   6
`define BIT_FOUR_BY_FOUR    5
`define BIT_LED_STATUS      0
`define BIT_DISPLAY_IRQ     6

// ---------------------------------------------------------------
// reset values and memory layout
// ---------------------------------------------------------------
`define RESET_BYTE          8'h00
`define DISP_BASE           16'h1000
`define DOT_BYTES           5'd14
`define MATRIX_BYTES        5'd8
`define DOT_SEL_OFFSET      4'd7

// ---------------------------------------------------------------
// time base: everything is counted in 2 us units
// ---------------------------------------------------------------
`define CLK_MHZ             200
`define UNIT_NS             2000
`define UNIT_CYCLES         ((`UNIT_NS * `CLK_MHZ) / 1000)
`define STEP_US             16
`define STEP_UNITS          ((`STEP_US * 1000) / `UNIT_NS)
`define COMMON_EXTRA_US     8
`define COMMON_EXTRA_UNITS  ((`COMMON_EXTRA_US * 1000) / `UNIT_NS)

`endif

//--- core/led_scan_pkg.sv
/*
  types shared by the lamp scan controller.
  assumes nothing of its surroundings.
*/
package led_scan_pkg;

  typedef enum logic [1:0] {
    SCAN_IDLE,
    SCAN_FETCH,
    SCAN_SLOT
  } scan_state_t;

endpackage : led_scan_pkg

//--- core/led_scan_display_driver.sv
/*
  lamp scan controller: special function and secondary bus registers,
  display memory fetch, dot matrix and row/column matrix pin timing.
  assumes an asynchronous display memory answering in the same cycle as the
  registered address, and single-cycle register read and write strobes.
*/
`timescale 1ns/1ps
`include "led_scan_regs.svh"

module led_scan_display_driver
  import led_scan_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // secondary bus port
  input  wire logic [7:0]  sec_addr,
  input  wire logic        sec_wr,
  input  wire logic        sec_rd,
  input  wire logic [7:0]  sec_wdata,
  output logic      [7:0]  sec_rdata,
  // display memory read port
  output logic      [15:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  // general-purpose output values for high-current mode
  input  wire logic [7:0]  gpio_out,
  // common line pads (port b)
  output logic      [7:0]  common_line_out,
  output logic      [7:0]  common_line_oe,
  // segment line pads
  output logic      [7:0]  segment_line_out,
  output logic      [7:0]  segment_line_oe,
  // to the interrupt controller and pad drivers
  output logic             display_irq,
  output logic             display_irq_priority,
  output logic      [3:0]  lamp_drive_code
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] status_reg, status_next;
  logic       scan_on_reg, scan_on_next;
  logic [7:0] control_reg, control_next;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] period1_reg, period1_next;
  logic [7:0] period2_reg, period2_next;
  logic [7:0] fourx_reg, fourx_next;
  logic [7:0] ien_reg, ien_next;
  logic [7:0] iflag_reg, iflag_next;
  logic [7:0] iprio_reg, iprio_next;
  logic [7:0] com_sel_reg, com_sel_next;
  logic [7:0] seg_sel_reg, seg_sel_next;
  logic [3:0] drive_reg, drive_next;
  logic [2:0] pad_reg, pad_next;
  logic [7:0] sfr_rdata_next, sec_rdata_next;
  logic       frame_done;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_comb begin
    status_next    = status_reg;
    scan_on_next   = scan_on_reg;
    control_next   = control_reg;
    mode_next      = mode_reg;
    period1_next   = period1_reg;
    period2_next   = period2_reg;
    fourx_next     = fourx_reg;
    ien_next       = ien_reg;
    iflag_next     = iflag_reg;
    iprio_next     = iprio_reg;
    com_sel_next   = com_sel_reg;
    seg_sel_next   = seg_sel_reg;
    drive_next     = drive_reg;
    pad_next       = pad_reg;
    sfr_rdata_next = sfr_rdata;
    sec_rdata_next = sec_rdata;
    if (sfr_wr) begin
      if (hit(sfr_addr, `OFS_IRQ_STATUS))
        status_next = sfr_wdata & status_reg;
      if (hit(sfr_addr, `OFS_SCAN_ON)) begin
        scan_on_next = sfr_wdata[0];
        status_next[`BIT_LED_STATUS] = 1'b0;
      end
      if (hit(sfr_addr, `OFS_DISP_CONTROL))
        control_next = {1'b0, sfr_wdata[6:0]};
      if (hit(sfr_addr, `OFS_DISP_MODE))
        mode_next = sfr_wdata;
      if (hit(sfr_addr, `OFS_FIRST_PERIOD))
        period1_next = sfr_wdata;
      if (hit(sfr_addr, `OFS_SECOND_PERIOD))
        period2_next = sfr_wdata;
      if (hit(sfr_addr, `OFS_FOUR_BY_FOUR))
        fourx_next = {1'b0, sfr_wdata[6:0]};
      if (hit(sfr_addr, `OFS_IRQ_ENABLE_ONE))
        ien_next = {sfr_wdata[7:2], 2'b00};
      if (hit(sfr_addr, `OFS_IRQ_FLAG_ONE))
        iflag_next = {sfr_wdata[7:2], 2'b00};
      if (hit(sfr_addr, `OFS_IRQ_PRIO_ONE))
        iprio_next = {sfr_wdata[7:2], 2'b00};
    end
    // end of frame wins over a clear in the same cycle
    if (frame_done) begin
      status_next[`BIT_LED_STATUS] = 1'b1;
      iflag_next[`BIT_DISPLAY_IRQ] = 1'b1;
    end
    if (sec_wr) begin
      if (hit(sec_addr, `OFS_COMMON_SELECT))
        com_sel_next = sec_wdata;
      if (hit(sec_addr, `OFS_SEGMENT_SELECT))
        seg_sel_next = sec_wdata;
      if (hit(sec_addr, `OFS_DRIVE_STRENGTH))
        drive_next = sec_wdata[3:0];
      if (hit(sec_addr, `OFS_START_PAD))
        pad_next = sec_wdata[2:0];
    end
    if (sfr_rd) begin
      unique case (sfr_addr)
        `OFS_IRQ_STATUS:     sfr_rdata_next = status_reg;
        `OFS_SCAN_ON:        sfr_rdata_next = {7'h00, scan_on_reg};
        `OFS_DISP_CONTROL:   sfr_rdata_next = control_reg;
        `OFS_DISP_MODE:      sfr_rdata_next = mode_reg;
        `OFS_FIRST_PERIOD:   sfr_rdata_next = period1_reg;
        `OFS_SECOND_PERIOD:  sfr_rdata_next = period2_reg;
        `OFS_FOUR_BY_FOUR:   sfr_rdata_next = fourx_reg;
        `OFS_IRQ_ENABLE_ONE: sfr_rdata_next = ien_reg;
        `OFS_IRQ_FLAG_ONE:   sfr_rdata_next = iflag_reg;
        `OFS_IRQ_PRIO_ONE:   sfr_rdata_next = iprio_reg;
        default:             sfr_rdata_next = 8'h00;
      endcase
    end
    if (sec_rd) begin
      unique case (sec_addr)
        `OFS_COMMON_SELECT:  sec_rdata_next = com_sel_reg;
        `OFS_SEGMENT_SELECT: sec_rdata_next = seg_sel_reg;
        `OFS_DRIVE_STRENGTH: sec_rdata_next = {4'h0, drive_reg};
        `OFS_START_PAD:      sec_rdata_next = {5'h00, pad_reg};
        default:             sec_rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_reg  <= `RESET_BYTE;
      scan_on_reg <= 1'b0;
      control_reg <= `RESET_BYTE;
      mode_reg    <= `RESET_BYTE;
      period1_reg <= `RESET_BYTE;
      period2_reg <= `RESET_BYTE;
      fourx_reg   <= `RESET_BYTE;
      ien_reg     <= `RESET_BYTE;
      iflag_reg   <= `RESET_BYTE;
      iprio_reg   <= `RESET_BYTE;
      com_sel_reg <= `RESET_BYTE;
      seg_sel_reg <= `RESET_BYTE;
      drive_reg   <= 4'h0;
      pad_reg     <= 3'h0;
      sfr_rdata   <= `RESET_BYTE;
      sec_rdata   <= `RESET_BYTE;
    end else begin
      status_reg  <= status_next;
      scan_on_reg <= scan_on_next;
      control_reg <= control_next;
      mode_reg    <= mode_next;
      period1_reg <= period1_next;
      period2_reg <= period2_next;
      fourx_reg   <= fourx_next;
      ien_reg     <= ien_next;
      iflag_reg   <= iflag_next;
      iprio_reg   <= iprio_next;
      com_sel_reg <= com_sel_next;
      seg_sel_reg <= seg_sel_next;
      drive_reg   <= drive_next;
      pad_reg     <= pad_next;
      sfr_rdata   <= sfr_rdata_next;
      sec_rdata   <= sec_rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------------
  logic        dot_mode, four_mode, lamp_engine, cyclic, hc_lock;
  logic [2:0]  duty;
  logic [2:0]  start_pin;
  logic [3:0]  pin_count;
  logic [11:0] on1_units, on2_units, group_units, seg_units, com_units;

  assign dot_mode    = mode_reg[`BIT_LAMP_MODE];
  assign four_mode   = fourx_reg[`BIT_FOUR_BY_FOUR];
  assign lamp_engine = control_reg[`BIT_ENGINE_SELECT];
  assign cyclic      = control_reg[`BIT_SCAN_CYCLIC];
  assign hc_lock     = control_reg[`BIT_HIGH_CURRENT];
  assign duty        = control_reg[`BIT_DUTY_HI:`BIT_DUTY_LO];
  // size 00..11 gives 5..8 pins; upper bit forces 4x5 from pin three
  assign pin_count   = control_reg[`BIT_DUTY_HI] ? 4'd5
                       : {2'b00, control_reg[4:3]} + 4'd5;
  assign start_pin   = control_reg[`BIT_DUTY_HI] ? 3'd3
                       : pad_reg;
  assign on1_units   = ({4'h0, period1_reg} + 12'd1)
                       * 12'(`STEP_UNITS);
  assign on2_units   = ({4'h0, period2_reg} + 12'd1)
                       * 12'(`STEP_UNITS);
  assign group_units = (on1_units > on2_units) ? on1_units
                       : on2_units;
  // conduction window is (duty+1) eighths of the segment slot
  assign seg_units   = ({4'h0, period1_reg} + 12'd1)
                       * ({9'h000, duty} + 12'd1);
  assign com_units   = on1_units + 12'(`COMMON_EXTRA_UNITS);

  // ---------------------------------------------------------------
  // scan sequencer
  // ---------------------------------------------------------------
  scan_state_t state_reg, state_next;
  logic [8:0]  pre_reg, pre_next;
  logic [11:0] unit_reg, unit_next;
  logic [3:0]  group_reg, group_next;
  logic [4:0]  fetch_reg, fetch_next;
  logic        cap_reg, cap_next;
  logic [3:0]  cap_idx_reg, cap_idx_next;
  logic        done_reg, done_next;
  logic [15:0] mem_addr_next;
  logic [7:0]  disp_reg [14];
  logic [7:0]  disp_next [14];
  logic        run, unit_tick, slot_end, skip_com, frame_wrap;
  logic [11:0] slot_units;
  logic [4:0]  fetch_len;
  logic [3:0]  group_len;

  // leaving the lamp engine or clearing scan-on drops all scan state
  assign run        = scan_on_reg & lamp_engine & ~hc_lock;
  assign unit_tick  = (pre_reg == 9'(`UNIT_CYCLES - 1));
  assign fetch_len  = dot_mode ? `DOT_BYTES : `MATRIX_BYTES;
  assign group_len  = dot_mode ? pin_count
                      : (four_mode ? 4'd4 : 4'd8);
  assign slot_units = dot_mode ? group_units : com_units;
  assign slot_end   = unit_tick & (unit_reg == slot_units - 12'd1);
  // unselected commons are skipped in a single cycle
  assign skip_com   = ~dot_mode & ~com_sel_reg[group_reg[2:0]];
  assign frame_wrap = (group_reg == group_len - 4'd1)
                      & (slot_end | skip_com);
  // flags rise on the last slot's final cycle, in both scan modes
  assign frame_done = (state_reg == SCAN_SLOT) & run & frame_wrap;

  always_comb begin
    state_next    = state_reg;
    pre_next      = unit_tick ? 9'h000 : pre_reg + 9'h001;
    unit_next     = unit_reg;
    group_next    = group_reg;
    fetch_next    = fetch_reg;
    cap_next      = 1'b0;
    cap_idx_next  = fetch_reg[3:0];
    done_next     = done_reg;
    mem_addr_next = mem_addr;
    disp_next     = disp_reg;
    if (cap_reg)
      disp_next[cap_idx_reg] = mem_rdata;
    unique case (state_reg)
      SCAN_IDLE: begin
        fetch_next = 5'd0;
        if (run && !done_reg)
          state_next = SCAN_FETCH;
      end
      SCAN_FETCH: begin
        if (fetch_reg < fetch_len) begin
          mem_addr_next = `DISP_BASE + {11'h000, fetch_reg};
          cap_next      = 1'b1;
          fetch_next    = fetch_reg + 5'd1;
        end else if (!cap_reg) begin
          state_next = SCAN_SLOT;
          group_next = 4'd0;
          unit_next  = 12'd0;
          pre_next   = 9'h000;
        end
      end
      SCAN_SLOT: begin
        if (unit_tick)
          unit_next = unit_reg + 12'd1;
        if (slot_end | skip_com) begin
          unit_next = 12'd0;
          pre_next  = 9'h000;
          if (frame_wrap) begin
            group_next = 4'd0;
            state_next = cyclic ? SCAN_FETCH : SCAN_IDLE;
            // interrupt mode parks until scan-on is cleared
            done_next  = ~cyclic;
            fetch_next = 5'd0;
          end else begin
            group_next = group_reg + 4'd1;
          end
        end
      end
    endcase
    if (!run) begin
      state_next = SCAN_IDLE;
      done_next  = 1'b0;
      group_next = 4'd0;
      unit_next  = 12'd0;
      pre_next   = 9'h000;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= SCAN_IDLE;
      pre_reg     <= 9'h000;
      unit_reg    <= 12'd0;
      group_reg   <= 4'd0;
      fetch_reg   <= 5'd0;
      cap_reg     <= 1'b0;
      cap_idx_reg <= 4'd0;
      done_reg    <= 1'b0;
      mem_addr    <= `DISP_BASE;
      for (int i = 0; i < 14; i++)
        disp_reg[i] <= 8'h00;
    end else begin
      state_reg   <= state_next;
      pre_reg     <= pre_next;
      unit_reg    <= unit_next;
      group_reg   <= group_next;
      fetch_reg   <= fetch_next;
      cap_reg     <= cap_next;
      cap_idx_reg <= cap_idx_next;
      done_reg    <= done_next;
      mem_addr    <= mem_addr_next;
      disp_reg    <= disp_next;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic [7:0] com_out_next, com_oe_next, seg_out_next, seg_oe_next;
  logic [7:0] com_out_int, com_oe_int;
  logic [5:0] lamp;
  logic [2:0] phys, other;
  logic       lit, active_com;

  always_comb begin
    com_out_next = 8'h00;
    com_oe_next  = 8'h00;
    seg_out_next = 8'h00;
    seg_oe_next  = 8'h00;
    com_out_int  = 8'h00;
    com_oe_int   = 8'h00;
    lamp         = 6'd0;
    phys         = 3'd0;
    other        = 3'd0;
    lit          = 1'b0;
    active_com   = (state_reg == SCAN_SLOT);
    if (hc_lock) begin
      // sink outputs follow gpio, enabled by common select, independent of other scan settings
      com_out_next = gpio_out;
      com_oe_next  = com_sel_reg;
    end else if (active_com && dot_mode) begin
      // common cathode on the group pin, anodes on the remaining pins
      phys = 3'(start_pin + group_reg[2:0]);
      com_oe_int[phys] = 1'b1;
      for (int j = 0; j < 7; j++) begin
        if (4'(j) < pin_count - 4'd1) begin
          other = (3'(j) < group_reg[2:0]) ? 3'(j) : 3'(j + 1);
          lamp  = 6'(group_reg * 4'd7) + 6'(j);
          lit   = disp_reg[lamp[5:3]][lamp[2:0]]
                  & ((disp_reg[4'(lamp[5:3]) + `DOT_SEL_OFFSET][lamp[2:0]])
                  ? (unit_reg < on2_units) : (unit_reg < on1_units));
          phys  = 3'(start_pin + other);
          com_out_int[phys] = lit;
          com_oe_int[phys]  = lit;
        end
      end
      com_out_next = com_out_int;
      com_oe_next  = com_oe_int;
    end else if (active_com && four_mode) begin
      if (com_sel_reg[group_reg[1:0]]) begin
        com_out_next[group_reg[1:0]] = fourx_reg[`BIT_COMMON_INVERT];
        com_oe_next[group_reg[1:0]]  = 1'b1;
        for (int s = 0; s < 4; s++) begin
          com_out_next[4 + s] = disp_reg[group_reg][s]
                                & (unit_reg < seg_units);
          com_oe_next[4 + s]  = com_sel_reg[4 + s];
        end
      end
    end else if (active_com && com_sel_reg[group_reg[2:0]]) begin
      com_out_next[group_reg[2:0]] = 1'b0;
      com_oe_next[group_reg[2:0]]  = 1'b1;
      seg_out_next = disp_reg[group_reg] & {8{unit_reg < seg_units}};
      seg_oe_next  = seg_sel_reg;
    end
    if (!control_reg[`BIT_PIN_ENABLE] && !hc_lock) begin
      com_oe_next = 8'h00;
      seg_oe_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      common_line_out      <= 8'h00;
      common_line_oe       <= 8'h00;
      segment_line_out     <= 8'h00;
      segment_line_oe      <= 8'h00;
      display_irq          <= 1'b0;
      display_irq_priority <= 1'b0;
      lamp_drive_code      <= 4'h0;
    end else begin
      common_line_out      <= com_out_next;
      common_line_oe       <= com_oe_next;
      segment_line_out     <= seg_out_next;
      segment_line_oe      <= seg_oe_next;
      display_irq          <= iflag_reg[`BIT_DISPLAY_IRQ]
                              & ien_reg[`BIT_DISPLAY_IRQ];
      display_irq_priority <= iprio_reg[`BIT_DISPLAY_IRQ];
      lamp_drive_code      <= drive_reg;
    end
  end

endmodule : led_scan_display_driver

//--- verification/led_scan_display_driver_asserts.sv
/* port checker of the lamp scan controller.
   assumes a bind onto led_scan_display_driver. */
`timescale 1ns/1ps
module led_scan_display_driver_asserts (
  // watched ports
  input wire logic core_clk, nrst, sfr_wr, sec_wr, display_irq,
  input wire logic display_irq_priority,
  input wire logic [7:0] sfr_addr, sfr_wdata, sec_addr, sec_wdata, gpio_out,
  input wire logic [7:0] common_line_out, common_line_oe, segment_line_oe,
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] lamp_drive_code
);
  logic [7:0] ctl_reg, ctl_next, mode_reg, mode_next, en_reg, en_next;
  logic [7:0] com_reg, com_next, seg_reg, seg_next;
  // shadows rebuilt from write strobes
  always_comb begin
    ctl_next = sfr_wr && sfr_addr == 8'hb1 ? sfr_wdata : ctl_reg;
    mode_next = sfr_wr && sfr_addr == 8'hb2 ? sfr_wdata : mode_reg;
    en_next = sfr_wr && sfr_addr == 8'he6 ? sfr_wdata : en_reg;
    com_next = sec_wr && sec_addr == 8'h23 ? sec_wdata : com_reg;
    seg_next = sec_wr && sec_addr == 8'h24 ? sec_wdata : seg_reg;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) {ctl_reg, mode_reg, en_reg, com_reg, seg_reg} <= '0;
    else {ctl_reg, mode_reg, en_reg, com_reg, seg_reg} <=
      {ctl_next, mode_next, en_next, com_next, seg_next};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // outputs trail the shadows by up to two edges, so wait for calm
  sequence calm(e);
    (e) [*3];
  endsequence
  AST_PRIO: assert property (sfr_wr && sfr_addr == 8'hf6 |->
    ##2 display_irq_priority == $past(sfr_wdata[6], 2)) else $error("prio");
  AST_DRIVE: assert property (sec_wr && sec_addr == 8'h31 |->
    ##2 lamp_drive_code == $past(sec_wdata[3:0], 2)) else $error("drive");
  AST_WINDOW: assert property (mem_addr[15:4] == 12'h100
    && mem_addr[3:0] <= 4'hd) else $error("memory address");
  AST_PINS_OFF: assert property (calm(!ctl_reg[0]
    && !(ctl_reg[6] && ctl_reg[2])) |-> (common_line_oe | segment_line_oe)
    == 8'h00) else $error("pins driven");
  AST_LOCK: assert property (calm(ctl_reg[0] && $stable(gpio_out)
    && $stable(com_reg)) |-> common_line_out == gpio_out
    && common_line_oe == com_reg) else $error("lock");
  AST_MASK: assert property (calm(!en_reg[6]) |-> !display_irq)
    else $error("masked irq");
  AST_SEG_SEL: assert property (calm($stable(seg_reg)) |->
    (segment_line_oe & ~seg_reg) == 8'h00) else $error("segment");
  AST_COM_SEL: assert property (calm($stable(com_reg) && !mode_reg[7])
    |-> (common_line_oe & ~com_reg) == 8'h00) else $error("common");
endmodule : led_scan_display_driver_asserts

//--- verification/display_memory_model.sv
/* display memory feeding the scan engine.
   assumes the bench loads cells before scanning. */
`timescale 1ns/1ps
module display_memory_model (
  // read port
  input wire logic [15:0] mem_addr,
  output logic     [7:0]  mem_rdata
);
  logic [7:0] cells [16];
  // answers at once, so data is valid in the same cycle as the address
  assign mem_rdata = mem_addr[15:4] == 12'h100 ?
    cells[mem_addr[3:0]] : 8'ha5;
endmodule : display_memory_model

//--- verification/led_scan_display_driver_bench.sv
/* bench: registers, high-current lock, matrix frame, cyclic dot frames.
   assumes checker and memory model are compiled first. */
`timescale 1ns/1ps
module led_scan_display_driver_bench;
  logic core_clk = 1'h0, nrst = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
  logic sec_wr = 1'h0, sec_rd = 1'h0, display_irq, display_irq_priority;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sec_addr = 8'h00;
  logic [7:0] sec_wdata = 8'h00, gpio_out = 8'h00, q;
  logic [7:0] sfr_rdata, sec_rdata, mem_rdata, segment_line_out;
  logic [7:0] common_line_out, common_line_oe, segment_line_oe;
  logic [15:0] mem_addr;
  logic [3:0] lamp_drive_code;
  int fails = 0, checked = 0, n;
  always #2.5 core_clk = ~core_clk;
  led_scan_display_driver u_led_scan_display_driver (.*);
  display_memory_model u_display_memory_model (.mem_addr, .mem_rdata);
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // one strobe on either bus, s picks the secondary one; read data to q
  task automatic acc(bit s, bit w, logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    if (s) {sec_addr, sec_wdata, sec_wr, sec_rd} <= {a, d, w, !w};
    else {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} <= {a, d, w, !w};
    @(posedge core_clk);
    {sec_wr, sec_rd, sfr_wr, sfr_rd} <= 4'h0;
    #1 q = s ? sec_rdata : sfr_rdata;
  endtask : acc
  task automatic till(bit irq, int lim);
    n = 0;
    while ((irq ? display_irq : common_line_oe[0]) !== 1'b1) begin
      @(posedge core_clk);
      #1 n++;
      if (n > lim) begin
        fails++;
        complete_run();
      end
    end
  endtask : till
  task automatic t_regs;
    acc(0, 1, 8'hb1, 8'hff);
    acc(0, 0, 8'hb1, 8'h00);
    chk("control", q, 8'h7f);
    acc(1, 1, 8'h31, 8'hff);
    acc(1, 0, 8'h31, 8'h00);
    chk("drive", q, 8'h0f);
    chk("drive code", {4'h0, lamp_drive_code}, 8'h0f);
    acc(0, 1, 8'hf6, 8'hff);
    acc(0, 0, 8'hf6, 8'h00);
    chk("priority reg", q, 8'hfc);
    chk("priority", {7'h00, display_irq_priority}, 8'h01);
    acc(0, 0, 8'h10, 8'h00);
    chk("unmapped", q, 8'h00);
    acc(0, 1, 8'hb1, 8'h00);
    $display("regs done");
  endtask : t_regs
  task automatic t_lock;
    @(posedge core_clk) gpio_out <= 8'ha5;
    acc(1, 1, 8'h23, 8'h0f);
    acc(0, 1, 8'hb1, 8'h01);
    repeat (3) @(posedge core_clk);
    #1 chk("lock oe", common_line_oe, 8'h0f);
    chk("lock out", common_line_out, 8'ha5);
    acc(0, 1, 8'hb1, 8'h00);
    $display("lock done");
  endtask : t_lock
  // one common selected, duty 2/8, interrupt mode
  task automatic t_matrix;
    for (int i = 0; i < 16; i++) u_display_memory_model.cells[i] = 8'h5a;
    acc(1, 1, 8'h23, 8'h01);
    acc(1, 1, 8'h24, 8'hff);
    acc(0, 1, 8'he6, 8'h40);
    acc(0, 1, 8'hb1, 8'h4c);
    acc(0, 1, 8'haf, 8'h01);
    till(0, 100);
    repeat (400) @(posedge core_clk);
    #1 chk("common low", {7'h00, common_line_out[0]}, 8'h00);
    chk("lit", segment_line_out & segment_line_oe, 8'h5a);
    repeat (800) @(posedge core_clk);
    #1 chk("dark", segment_line_out & segment_line_oe, 8'h00);
    till(1, 5000);
    chk("slot", {7'h00, n > 3597 && n < 3630}, 8'h01);
    acc(0, 0, 8'hf1, 8'h00);
    chk("flag", q, 8'h40);
    acc(0, 0, 8'hae, 8'h00);
    chk("status", q, 8'h01);
    acc(0, 1, 8'hae, 8'h00);
    acc(0, 1, 8'hf1, 8'h00);
    acc(0, 0, 8'hae, 8'h00);
    chk("status clear", q, 8'h00);
    repeat (6000) @(posedge core_clk);
    #1 chk("one frame", {7'h00, display_irq}, 8'h00);
    $display("matrix done");
  endtask : t_matrix
  // dot mode 4x5 from pad 0, cyclic, on-time 2 longer than on-time 1
  task automatic t_dot;
    acc(0, 1, 8'haf, 8'h00);
    acc(0, 1, 8'hb2, 8'h80);
    acc(0, 1, 8'hb4, 8'h01);
    acc(0, 1, 8'hb1, 8'h46);
    acc(0, 1, 8'haf, 8'h01);
    till(0, 100);
    chk("dot oe", common_line_oe, 8'h15);
    chk("dot out", common_line_out, 8'h14);
    till(1, 33000);
    chk("dot frame", {7'h00, n > 31900 && n < 32100}, 8'h01);
    acc(0, 1, 8'hf1, 8'h00);
    repeat (30) @(posedge core_clk);
    #1 chk("restart", common_line_oe, 8'h15);
    $display("dot done");
  endtask : t_dot
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'h1;
    t_regs();
    t_lock();
    t_matrix();
    t_dot();
    complete_run();
  end
endmodule : led_scan_display_driver_bench
bind led_scan_display_driver led_scan_display_driver_asserts u_chk (.*);
